// [core/tcr_pkg.sv]
// Constants, register map and mode decoding for the 16-bit timer
package tcr_pkg;

	// ==========================================================
	// Bus geometry
	localparam int AW = 5;
	localparam int DW = 32;
	localparam int BW = DW / 8;

	// ==========================================================
	// Register byte offsets
	localparam logic [AW-1:0] ADDR_CTRL   = 5'h00;
	localparam logic [AW-1:0] ADDR_COUNT  = 5'h04;
	localparam logic [AW-1:0] ADDR_RELOAD = 5'h08;
	localparam logic [AW-1:0] ADDR_STATUS = 5'h0c;
	localparam logic [AW-1:0] ADDR_MASK   = 5'h10;

	// ==========================================================
	// Control register fields
	localparam int CTL_OVF  = 7;
	localparam int CTL_EXT  = 6;
	localparam int CTL_RXS  = 5;
	localparam int CTL_TXS  = 4;
	localparam int CTL_TEN  = 3;
	localparam int CTL_RUN  = 2;
	localparam int CTL_CSEL = 1;
	localparam int CTL_CAP  = 0;
	localparam int CTL_WR_W = 6;

	// Status and mask fields
	localparam int STS_OVF = 0;
	localparam int STS_EXT = 1;
	localparam int STS_W   = 2;

	// ==========================================================
	// Reset values
	localparam logic [CTL_WR_W-1:0] CTRL_RST   = 6'h00;
	localparam logic [15:0]         COUNT_RST  = 16'h0000;
	localparam logic [15:0]         RELOAD_RST = 16'h0000;
	localparam logic [STS_W-1:0]    STS_RST    = 2'h0;
	localparam logic [STS_W-1:0]    MASK_RST   = 2'h0;

	// ==========================================================
	// Timing: one machine cycle is twelve oscillator periods
	localparam int MC_OSC_PERIODS = 12;
	localparam int CLK_PERIOD_NS  = 5;
	localparam int MC_NS          = MC_OSC_PERIODS * CLK_PERIOD_NS;
	localparam int MC_CYCLES      = MC_NS / CLK_PERIOD_NS;

	// ==========================================================
	// Operating modes
	typedef enum logic [1:0] {
		MODE_OFF     = 2'b00,
		MODE_RELOAD  = 2'b01,
		MODE_CAPTURE = 2'b10,
		MODE_BAUD    = 2'b11
	} tcr_mode_e;

	function automatic tcr_mode_e tcr_decode_mode(
		input logic [CTL_WR_W-1:0] ctrl
	);
		if (!ctrl[CTL_RUN]) begin
			return MODE_OFF;
		end else if (ctrl[CTL_RXS] || ctrl[CTL_TXS]) begin
			return MODE_BAUD;
		end else if (ctrl[CTL_CAP]) begin
			return MODE_CAPTURE;
		end else begin
			return MODE_RELOAD;
		end
	endfunction

endpackage

// [core/tcr_fall_detect.sv]
// Registered falling-edge detector for a synchronous pin
`timescale 1ns/10ps
`default_nettype none

module tcr_fall_detect (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_srst,
	// Pin and edge pulse
	input  wire logic i_level,
	output var  logic o_fall
);

	logic prev_r;

	// Reset to low so a pin held low at start gives no edge
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			prev_r <= 1'b0;
		end else begin
			prev_r <= i_level;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_fall <= 1'b0;
		end else begin
			o_fall <= prev_r & ~i_level;
		end
	end

endmodule // tcr_fall_detect

`default_nettype wire

// [core/tcr_cycle_tick.sv]
// Machine-cycle tick: one pulse every DIV clock periods
`timescale 1ns/10ps
`default_nettype none

module tcr_cycle_tick #(
	parameter int DIV = tcr_pkg::MC_CYCLES
) (
	// Clock and reset
	input  wire logic i_clk,
	input  wire logic i_srst,
	// Tick
	output var  logic o_tick
);

	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_r;

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			cnt_r <= '0;
		end else if (cnt_r == LAST) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_r + 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_tick <= 1'b0;
		end else begin
			o_tick <= (cnt_r == LAST);
		end
	end

endmodule // tcr_cycle_tick

`default_nettype wire

// [core/tcr_timer.sv]
// 16-bit timer/counter with capture, auto-reload and baud modes
`timescale 1ns/10ps
`default_nettype none

module tcr_timer #(
	parameter int TICK_DIV = tcr_pkg::MC_CYCLES
) (
	// Clock and reset
	input  wire logic                    i_clk,
	input  wire logic                    i_srst,
	// Avalon-MM slave
	input  wire logic [tcr_pkg::AW-1:0]  i_avs_address,
	input  wire logic                    i_avs_read,
	input  wire logic                    i_avs_write,
	input  wire logic [tcr_pkg::DW-1:0]  i_avs_writedata,
	input  wire logic [tcr_pkg::BW-1:0]  i_avs_byteenable,
	output var  logic [tcr_pkg::DW-1:0]  o_avs_readdata,
	output logic                         o_avs_waitrequest,
	// External pins
	input  wire logic                    i_count_pin,
	input  wire logic                    i_trigger_pin,
	// Serial port clocking
	input  wire logic                    i_other_timer_ovf,
	output var  logic                    o_serial_rx_clk,
	output var  logic                    o_serial_tx_clk,
	// Interrupt
	output logic                         o_irq
);

	import tcr_pkg::*;

	// ==========================================================
	// Declarations
	logic [CTL_WR_W-1:0] ctrl_r;
	logic [15:0]         count_r;
	logic [15:0]         reload_r;
	logic [STS_W-1:0]    sts_r;
	logic [STS_W-1:0]    sts_nxt;
	logic [STS_W-1:0]    mask_r;
	logic                ack_r;
	logic                fire;
	logic                wr_ctrl;
	logic                wr_count;
	logic                wr_reload;
	logic                wr_status;
	logic                wr_mask;
	logic                tick;
	logic                cnt_fall;
	logic                trig_fall;
	logic                step;
	logic                trig;
	logic                wrap;
	logic [DW-1:0]       rd_mux;
	tcr_mode_e           mode;

	// Merge write data into a 16-bit register by byte lane
	function automatic logic [15:0] lane_merge(
		input logic [15:0]   old,
		input logic [DW-1:0] wdata,
		input logic [BW-1:0] be
	);
		logic [15:0] res;
		res = old;
		if (be[0]) begin
			res[7:0] = wdata[7:0];
		end
		if (be[1]) begin
			res[15:8] = wdata[15:8];
		end
		return res;
	endfunction

	// ==========================================================
	// Event sources
	tcr_cycle_tick #(
		.DIV (TICK_DIV)
	) u_tick (
		.i_clk  (i_clk),
		.i_srst (i_srst),
		.o_tick (tick)
	);

	tcr_fall_detect u_count_edge (
		.i_clk   (i_clk),
		.i_srst  (i_srst),
		.i_level (i_count_pin),
		.o_fall  (cnt_fall)
	);

	tcr_fall_detect u_trig_edge (
		.i_clk   (i_clk),
		.i_srst  (i_srst),
		.i_level (i_trigger_pin),
		.o_fall  (trig_fall)
	);

	// ==========================================================
	// Avalon slave: one wait state on every access
	assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
	assign fire      = i_avs_write & ack_r;
	assign wr_ctrl   = fire & (i_avs_address == ADDR_CTRL);
	assign wr_count  = fire & (i_avs_address == ADDR_COUNT);
	assign wr_reload = fire & (i_avs_address == ADDR_RELOAD);
	assign wr_status = fire & (i_avs_address == ADDR_STATUS);
	assign wr_mask   = fire & (i_avs_address == ADDR_MASK);

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= (i_avs_read | i_avs_write) & ~ack_r;
		end
	end

	// Unmapped addresses read as zero
	always_comb begin
		rd_mux = '0;
		unique case (i_avs_address)
			ADDR_CTRL: begin
				rd_mux[7:0] = {sts_r[STS_OVF], sts_r[STS_EXT], ctrl_r};
			end
			ADDR_COUNT: begin
				rd_mux[15:0] = count_r;
			end
			ADDR_RELOAD: begin
				rd_mux[15:0] = reload_r;
			end
			ADDR_STATUS: begin
				rd_mux[STS_W-1:0] = sts_r;
			end
			ADDR_MASK: begin
				rd_mux[STS_W-1:0] = mask_r;
			end
			default: begin
				rd_mux = '0;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_avs_readdata <= '0;
		end else if (i_avs_read & ~ack_r) begin
			o_avs_readdata <= rd_mux;
		end
	end

	// ==========================================================
	// Control and mask registers
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			ctrl_r <= CTRL_RST;
		end else if (wr_ctrl & i_avs_byteenable[0]) begin
			ctrl_r <= i_avs_writedata[CTL_WR_W-1:0];
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			mask_r <= MASK_RST;
		end else if (wr_mask & i_avs_byteenable[0]) begin
			mask_r <= i_avs_writedata[STS_W-1:0];
		end
	end

	// ==========================================================
	// Mode and counting events
	assign mode = tcr_decode_mode(ctrl_r);

	always_comb begin
		step = 1'b0;
		trig = 1'b0;
		unique case (mode)
			MODE_OFF: begin
				step = 1'b0;
				trig = 1'b0;
			end
			MODE_RELOAD, MODE_CAPTURE: begin
				step = ctrl_r[CTL_CSEL] ? cnt_fall : tick;
				trig = trig_fall & ctrl_r[CTL_TEN];
			end
			MODE_BAUD: begin
				step = ctrl_r[CTL_CSEL] ? cnt_fall : tick;
				trig = 1'b0;
			end
		endcase
	end

	assign wrap = step & (count_r == 16'hffff);

	// ==========================================================
	// Count register
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			count_r <= COUNT_RST;
		end else if (wr_count) begin
			count_r <= lane_merge(count_r, i_avs_writedata,
				i_avs_byteenable);
		end else begin
			unique case (mode)
				MODE_OFF: begin
					count_r <= count_r;
				end
				MODE_CAPTURE: begin
					if (step) begin
						count_r <= count_r + 16'h0001;
					end
				end
				MODE_RELOAD, MODE_BAUD: begin
					if (trig | wrap) begin
						count_r <= reload_r;
					end else if (step) begin
						count_r <= count_r + 16'h0001;
					end
				end
			endcase
		end
	end

	// Hardware capture beats a same-cycle software write
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			reload_r <= RELOAD_RST;
		end else if (trig && mode == MODE_CAPTURE) begin
			reload_r <= count_r;
		end else if (wr_reload) begin
			reload_r <= lane_merge(reload_r, i_avs_writedata,
				i_avs_byteenable);
		end
	end

	// ==========================================================
	// Sticky flags, write one to clear, set wins
	always_comb begin
		sts_nxt = sts_r;
		if (wr_status & i_avs_byteenable[0]) begin
			sts_nxt = sts_r & ~i_avs_writedata[STS_W-1:0];
		end
		if (wrap && mode != MODE_BAUD) begin
			sts_nxt[STS_OVF] = 1'b1;
		end
		if (trig) begin
			sts_nxt[STS_EXT] = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			sts_r <= STS_RST;
		end else begin
			sts_r <= sts_nxt;
		end
	end

	assign o_irq = |(sts_r & mask_r);

	// ==========================================================
	// Serial clock sources
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_serial_rx_clk <= 1'b0;
			o_serial_tx_clk <= 1'b0;
		end else begin
			o_serial_rx_clk <= ctrl_r[CTL_RXS] ? wrap
				: i_other_timer_ovf;
			o_serial_tx_clk <= ctrl_r[CTL_TXS] ? wrap
				: i_other_timer_ovf;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_srst);

	sequence s_wrap_in_reload;
		wrap && mode == MODE_RELOAD && !wr_count;
	endsequence

	sequence s_trig_in_reload;
		trig_fall && ctrl_r[CTL_TEN] && mode == MODE_RELOAD && !wr_count;
	endsequence

	sequence s_trig_in_capture;
		trig_fall && ctrl_r[CTL_TEN] && mode == MODE_CAPTURE;
	endsequence

	a_off_holds: assert property (
		mode == MODE_OFF && !wr_count |=> $stable(count_r))
		else $error("count moved while stopped");

	a_mode_decode: assert property (
		ctrl_r[CTL_RUN] && (ctrl_r[CTL_RXS] || ctrl_r[CTL_TXS])
		|-> mode == MODE_BAUD)
		else $error("baud mode not selected");

	a_ovf_flag_set: assert property (
		$rose(sts_r[STS_OVF]) |-> $past(wrap) && $past(mode) != MODE_BAUD)
		else $error("overflow flag set without cause");

	a_ovf_flag_wrap: assert property (
		wrap && mode == MODE_CAPTURE |=> sts_r[STS_OVF])
		else $error("overflow flag missed");

	a_ext_flag_cause: assert property (
		$rose(sts_r[STS_EXT]) |-> $past(trig))
		else $error("external flag set without trigger");

	a_wrap_reload: assert property (
		s_wrap_in_reload |=> count_r == $past(reload_r) && sts_r[STS_OVF])
		else $error("rollover did not reload");

	a_trig_reload: assert property (
		s_trig_in_reload |=> count_r == $past(reload_r) && sts_r[STS_EXT])
		else $error("trigger did not reload");

	a_capture_copy: assert property (
		s_trig_in_capture |=> reload_r == $past(count_r) && sts_r[STS_EXT])
		else $error("trigger did not capture");

	a_baud_ignores: assert property (
		mode == MODE_BAUD && !wr_reload |=> $stable(reload_r)
		&& !$rose(sts_r[STS_EXT]))
		else $error("trigger acted in baud mode");

	a_counter_pin: assert property (
		mode == MODE_CAPTURE && ctrl_r[CTL_CSEL] && !cnt_fall && !wr_count
		|=> $stable(count_r))
		else $error("counter moved without pin edge");

	a_count_step: assert property (
		mode == MODE_CAPTURE && step && !wrap && !wr_count
		|=> count_r == $past(count_r) + 16'h0001)
		else $error("count did not advance by one");

	a_tx_clock: assert property (
		ctrl_r[CTL_TXS] && wrap |=> o_serial_tx_clk)
		else $error("transmit clock pulse missing");

	a_sw_load: assert property (
		wr_count && i_avs_byteenable[1:0] == 2'h3
		|=> count_r == $past(i_avs_writedata[15:0]))
		else $error("software count load lost");

endmodule // tcr_timer

`default_nettype wire

// [verif/tcr_pin_model.sv]
// Behavioural model of the external count and trigger pins
`timescale 1ns/10ps
`default_nettype none

module tcr_pin_model (
	// Clock
	input  wire logic i_clk,
	// Pins, idle high as with a pull-up
	output var  logic o_count_pin,
	output var  logic o_trigger_pin
);
	initial begin
		o_count_pin = 1'b1;
		o_trigger_pin = 1'b1;
	end

	// ==========================================================
	// Falling edges
	// Two cycles low and two high, so each edge is seen and acted on
	task automatic fall(input logic trg, input int n);
		repeat (n) begin
			if (trg) begin
				o_trigger_pin <= 1'b0;
			end else begin
				o_count_pin <= 1'b0;
			end
			repeat (2) @(posedge i_clk);
			o_trigger_pin <= 1'b1;
			o_count_pin <= 1'b1;
			repeat (2) @(posedge i_clk);
		end
	endtask
endmodule // tcr_pin_model

`default_nettype wire

// [verif/tcr_timer_tb.sv]
// Register-level testbench for the 16-bit timer
`timescale 1ns/10ps
`default_nettype none

`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
	bad_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tcr_timer_tb;
	import tcr_pkg::*;

	logic          i_clk = 1'b0;
	logic          i_srst = 1'b1;
	logic          rd = 1'b0;
	logic          wr_s = 1'b0;
	logic          oth = 1'b0;
	logic [AW-1:0] adr = '0;
	logic [DW-1:0] wd = '0;
	logic [BW-1:0] be = '0;
	logic [DW-1:0] rdat;
	logic [DW-1:0] q;
	logic          wq, irq, rxc, txc, cp, tp;
	int            bad_count = 0;
	int            check_count = 0;
	int            cyc = 0;
	int            rx_n = 0;
	int            tx_n = 0;
	int            r0, t0;

	always #2.5 i_clk = ~i_clk;

	tcr_pin_model pins (.i_clk(i_clk), .o_count_pin(cp), .o_trigger_pin(tp));

	// Short machine cycle keeps the run brief
	tcr_timer #(.TICK_DIV(2)) dut (
		.i_clk(i_clk), .i_srst(i_srst),
		.i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr_s),
		.i_avs_writedata(wd), .i_avs_byteenable(be),
		.o_avs_readdata(rdat), .o_avs_waitrequest(wq),
		.i_count_pin(cp), .i_trigger_pin(tp),
		.i_other_timer_ovf(oth), .o_serial_rx_clk(rxc),
		.o_serial_tx_clk(txc), .o_irq(irq)
	);

	always @(posedge i_clk) begin
		rx_n <= rx_n + ((rxc === 1'b1) ? 1 : 0);
		tx_n <= tx_n + ((txc === 1'b1) ? 1 : 0);
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			bad_count++;
			final_report();
		end
	end

	// ==========================================================
	// Bus access
	// Design state moves by NBA, so pre-edge values are read here
	task automatic bus(input logic w, input logic [AW-1:0] a,
			input logic [DW-1:0] d, input logic [BW-1:0] b);
		adr <= a;
		wd <= d;
		be <= b;
		rd <= !w;
		wr_s <= w;
		// Only the bench timeout ends a stuck wait
		do begin
			@(posedge i_clk);
		end while (wq !== 1'b0);
		q = rdat;
		rd <= 1'b0;
		wr_s <= 1'b0;
		@(posedge i_clk);
	endtask

	task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask

	task automatic rc(input logic [AW-1:0] a, input logic [DW-1:0] e);
		bus(1'b0, a, 32'h0, 4'hf);
		`CHK(q, e)
	endtask

	task automatic done(input string s);
		$display("test %s done", s);
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// ==========================================================
	// Tests
	initial begin
		repeat (20) @(posedge i_clk);
		i_srst <= 1'b0;
		@(posedge i_clk);
		for (int i = 0; i < 6; i++) rc(5'(i * 4), 32'h0);
		done("reset");
		wr(ADDR_COUNT, 32'h1234);
		wr(ADDR_RELOAD, 32'habcd);
		bus(1'b1, ADDR_COUNT, 32'hff77, 4'h1);
		rc(ADDR_COUNT, 32'h1277);
		rc(ADDR_RELOAD, 32'habcd);
		wr(ADDR_CTRL, 32'hc2);
		rc(ADDR_CTRL, 32'h02);
		pins.fall(1'b0, 3);
		rc(ADDR_COUNT, 32'h1277);
		rc(ADDR_STATUS, 32'h0);
		done("preset and stop");
		wr(ADDR_RELOAD, 32'h1000);
		wr(ADDR_COUNT, 32'hfffe);
		wr(ADDR_CTRL, 32'h06);
		pins.fall(1'b0, 1);
		rc(ADDR_COUNT, 32'hffff);
		pins.fall(1'b0, 1);
		rc(ADDR_COUNT, 32'h1000);
		rc(ADDR_STATUS, 32'h1);
		rc(ADDR_CTRL, 32'h86);
		`CHK(irq, 1'b0)
		wr(ADDR_MASK, 32'h3);
		`CHK(irq, 1'b1)
		wr(ADDR_STATUS, 32'h1);
		`CHK(irq, 1'b0)
		done("reload overflow and irq");
		wr(ADDR_CTRL, 32'h0e);
		wr(ADDR_COUNT, 32'h5);
		pins.fall(1'b1, 1);
		rc(ADDR_COUNT, 32'h1000);
		rc(ADDR_STATUS, 32'h2);
		`CHK(irq, 1'b1)
		wr(ADDR_STATUS, 32'h3);
		wr(ADDR_CTRL, 32'h0f);
		wr(ADDR_COUNT, 32'h4321);
		pins.fall(1'b1, 1);
		rc(ADDR_RELOAD, 32'h4321);
		rc(ADDR_COUNT, 32'h4321);
		rc(ADDR_STATUS, 32'h2);
		wr(ADDR_STATUS, 32'h3);
		done("trigger reload and capture");
		wr(ADDR_CTRL, 32'h07);
		wr(ADDR_COUNT, 32'hffff);
		pins.fall(1'b0, 1);
		rc(ADDR_COUNT, 32'h0);
		pins.fall(1'b1, 1);
		rc(ADDR_RELOAD, 32'h4321);
		rc(ADDR_STATUS, 32'h1);
		wr(ADDR_STATUS, 32'h3);
		done("plain capture mode");
		wr(ADDR_RELOAD, 32'h2000);
		wr(ADDR_CTRL, 32'h2e);
		wr(ADDR_COUNT, 32'hffff);
		pins.fall(1'b1, 1);
		rc(ADDR_COUNT, 32'hffff);
		rc(ADDR_STATUS, 32'h0);
		r0 = rx_n;
		t0 = tx_n;
		pins.fall(1'b0, 1);
		rc(ADDR_COUNT, 32'h2000);
		rc(ADDR_STATUS, 32'h0);
		`CHK(rx_n - r0, 1)
		oth <= 1'b1;
		@(posedge i_clk);
		oth <= 1'b0;
		repeat (3) @(posedge i_clk);
		`CHK(tx_n - t0, 1)
		`CHK(rx_n - r0, 1)
		wr(ADDR_CTRL, 32'h1e);
		wr(ADDR_COUNT, 32'hffff);
		pins.fall(1'b0, 1);
		rc(ADDR_STATUS, 32'h0);
		`CHK(tx_n - t0, 2)
		`CHK(rx_n - r0, 1)
		done("baud mode");
		wr(ADDR_CTRL, 32'h0);
		wr(ADDR_COUNT, 32'h0);
		wr(ADDR_CTRL, 32'h04);
		repeat (40) @(posedge i_clk);
		wr(ADDR_CTRL, 32'h0);
		bus(1'b0, ADDR_COUNT, 32'h0, 4'hf);
		`CHK((q >= 32'd18 && q <= 32'd24), 1'b1)
		done("machine cycle timer");
		final_report();
	end
endmodule // tcr_timer_tb

`default_nettype wire
